// >>> design/epr_pkg.sv
/*
  Constants and helper functions for the ECC program memory.
  Assumes a single clock shared with the fetching processor.
*/
package epr_pkg;
  localparam int ADDR_W     = 12;
  localparam int INSTR_W    = 18;
  localparam int ROW_W      = 9;
  localparam int ROWS       = 512;
  localparam int SLOT_LO    = 9;
  localparam int DATA_W     = 64;
  localparam int CHECK_W    = 8;
  localparam int WORD_W     = 72;
  localparam int SPARE_W    = 10;
  localparam int SLOTS      = 3;
  localparam int GROUP_WORDS = 4;
  localparam int GROUPS     = ROWS / GROUP_WORDS;
  localparam logic [2:0] LAST_SLOT = 3'h2;
  localparam logic [INSTR_W-1:0] ZERO_INSTR = 18'h00000;

  // Hamming position of data bit d (positions that are not powers of two)
  function automatic logic [6:0] data_pos(input int d);
    int p;
    int k;
    p = 0;
    k = -1;
    for (int i = 1; i < 128; i++) begin
      if ((i & (i - 1)) != 0 && k < d) begin
        k++;
        p = i;
      end
    end
    return p[6:0];
  endfunction

  // Seven Hamming bits plus overall parity, packed as [7]=overall
  function automatic logic [CHECK_W-1:0] ecc_encode(
    input logic [DATA_W-1:0] d);
    logic [CHECK_W-1:0] c;
    logic [6:0]         p;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      p = data_pos(i);
      if (d[i]) begin
        c[6:0] = c[6:0] ^ p;
      end
    end
    c[7] = (^d) ^ (^c[6:0]);
    return c;
  endfunction
endpackage

// >>> design/epr_fetch_if.sv
/*
  Fetch path between the storage row and the selector.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface epr_fetch_if;
  logic [epr_pkg::DATA_W-1:0]  data;
  logic [epr_pkg::CHECK_W-1:0] check;
  logic [epr_pkg::DATA_W-1:0]  fixed;
  logic                        sbe;
  logic                        dbe;
  modport mem (output data, output check, input fixed, input sbe, input dbe);
  modport dec (input data, input check, output fixed, output sbe, output dbe);
endinterface

// >>> design/epr_ecc_dec.sv
/*
  Combinational SECDED decoder for one 72-bit stored word.
  Assumes the check byte was made by epr_pkg::ecc_encode.
*/
`timescale 1ns/1ps
module epr_ecc_dec (
  epr_fetch_if.dec f
);
  logic [6:0] syn;
  logic       par;
  logic [6:0] p;

  always_comb begin
    syn = f.check[6:0];
    for (int i = 0; i < epr_pkg::DATA_W; i++) begin
      p = epr_pkg::data_pos(i);
      if (f.data[i]) begin
        syn = syn ^ p;
      end
    end
    par = (^f.data) ^ (^f.check);
  end

  // Flip the one data bit named by the syndrome
  always_comb begin
    f.fixed = f.data;
    for (int i = 0; i < epr_pkg::DATA_W; i++) begin
      if (par && syn == epr_pkg::data_pos(i)) begin
        f.fixed[i] = ~f.data[i];
      end
    end
    f.sbe = par;
    f.dbe = !par && (syn != 7'h00);
  end
endmodule

// >>> design/epr_rom.sv
/*
  ECC-protected program memory: three instructions per 72-bit row.
  Assumes fetches come from a processor on the same clock; contents
  are fixed at elaboration from the init group parameters.
*/
`timescale 1ns/1ps
// What this block does
// - Each stored row carries three instructions whose addresses differ by 512.
// - Each row also holds ten spare bits and an eight-bit check code.
// - Instructions and spare bits form the 64-bit data field; check is apart.
// - Contents load in groups of four consecutive data words from word zero.
// - Fetching any of the three instructions of a bad row raises its flag.
// - A single-bit error in a row is corrected on every read.
// - The port takes a 12-bit address, enable and clock, returns 18 bits.
// - Two separate outputs flag corrected single and uncorrectable double errors.
// - Address bits 11:9 pick the slot and bits 8:0 pick the row.
// - Addresses 600 to FFF return zero or the default jump instruction.
// - The single flag rises again on each read of a still-bad row.
module epr_rom #(
  parameter logic [epr_pkg::DATA_W*epr_pkg::GROUP_WORDS-1:0]
    DATA_INIT_GROUP [epr_pkg::GROUPS] = '{default: '0},
  parameter logic [epr_pkg::CHECK_W*epr_pkg::GROUP_WORDS-1:0]
    CHECK_INIT_GROUP [epr_pkg::GROUPS] = '{default: '0},
  parameter bit   CHECK_FROM_DATA = 1'b1,
  parameter bit   USE_DEFAULT_JUMP = 1'b0,
  parameter logic [epr_pkg::INSTR_W-1:0] DEFAULT_JUMP = 18'h00000
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  input  wire logic [epr_pkg::ADDR_W-1:0]   i_address,
  input  wire logic                         i_enable,
  output logic      [epr_pkg::INSTR_W-1:0]  o_instruction,
  output logic                              o_single_error_flag,
  output logic                              o_double_error_flag
);
  typedef logic [epr_pkg::WORD_W-1:0] epr_word_t;

  epr_word_t                     mem [epr_pkg::ROWS];
  epr_word_t                     row_rd;
  logic [2:0]                    slot_sel;
  logic [epr_pkg::INSTR_W-1:0]   instr_nxt;
  logic [epr_pkg::INSTR_W-1:0]   instr_r;
  logic                          single_nxt;
  logic                          single_r;
  logic                          double_nxt;
  logic                          double_r;
  epr_fetch_if                   fi ();

  // Word w sits in group w/4, lane w%4, lowest lane first
  function automatic epr_word_t init_word(input int w);
    logic [epr_pkg::DATA_W-1:0]  d;
    logic [epr_pkg::CHECK_W-1:0] c;
    d = DATA_INIT_GROUP[w / epr_pkg::GROUP_WORDS]
          [(w % epr_pkg::GROUP_WORDS) * epr_pkg::DATA_W +: epr_pkg::DATA_W];
    c = CHECK_INIT_GROUP[w / epr_pkg::GROUP_WORDS]
          [(w % epr_pkg::GROUP_WORDS) * epr_pkg::CHECK_W +: epr_pkg::CHECK_W];
    if (CHECK_FROM_DATA) begin
      c = epr_pkg::ecc_encode(d);
    end
    return {c, d};
  endfunction

  // Forced value for slots past the last packed instruction
  function automatic logic [epr_pkg::INSTR_W-1:0] fill_instr();
    if (USE_DEFAULT_JUMP) begin
      return DEFAULT_JUMP;
    end
    return epr_pkg::ZERO_INSTR;
  endfunction

  // Slot s holds the instruction at row + 512*s
  function automatic logic [epr_pkg::INSTR_W-1:0] pick_slot(
    input logic [epr_pkg::DATA_W-1:0] d,
    input logic [2:0]                 s);
    logic [epr_pkg::INSTR_W-1:0] r;
    if (s > epr_pkg::LAST_SLOT) begin
      r = fill_instr();
    end else begin
      r = d[s[1:0]*epr_pkg::INSTR_W +: epr_pkg::INSTR_W];
    end
    return r;
  endfunction

  // Read-only storage built once; never rewritten with corrected data
  always_comb begin
    for (int w = 0; w < epr_pkg::ROWS; w++) begin
      mem[w] = init_word(w);
    end
  end

  // Row and slot come straight from the fetch address
  always_comb begin
    row_rd   = mem[i_address[epr_pkg::ROW_W-1:0]];
    slot_sel = i_address[epr_pkg::ADDR_W-1:epr_pkg::SLOT_LO];
  end

  assign fi.data  = row_rd[epr_pkg::DATA_W-1:0];
  assign fi.check = row_rd[epr_pkg::WORD_W-1:epr_pkg::DATA_W];

  // Decode ahead of the register: costs clock rate, gives flop outputs
  epr_ecc_dec u_dec (
    .f (fi)
  );

  always_comb begin
    instr_nxt  = pick_slot(fi.fixed, slot_sel);
    single_nxt = fi.sbe;
    double_nxt = fi.dbe;
  end

  // Instruction register; holds while enable is low
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      instr_r <= epr_pkg::ZERO_INSTR;
    end else if (i_enable) begin
      instr_r <= instr_nxt;
    end
  end

  // Single flag; row-wide, whatever slot is chosen
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      single_r <= 1'b0;
    end else if (i_enable) begin
      single_r <= single_nxt;
    end
  end

  // Double flag; row-wide, whatever slot is chosen
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      double_r <= 1'b0;
    end else if (i_enable) begin
      double_r <= double_nxt;
    end
  end

  assign o_instruction       = instr_r;
  assign o_single_error_flag = single_r;
  assign o_double_error_flag = double_r;

  dbl_excl_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(o_single_error_flag && o_double_error_flag))
    else $error("both error flags high");

  clean_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && epr_pkg::ecc_encode(fi.data) == fi.check
    |=> !o_single_error_flag && !o_double_error_flag)
    else $error("flag on clean row");

  out_range_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable &&
      i_address[epr_pkg::ADDR_W-1:epr_pkg::SLOT_LO] > epr_pkg::LAST_SLOT
    |=> o_instruction ==
      (USE_DEFAULT_JUMP ? DEFAULT_JUMP : epr_pkg::ZERO_INSTR))
    else $error("out of range fetch not forced");

  hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_enable |=> $stable(o_instruction))
    else $error("instruction moved without enable");

  slot_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && i_address[epr_pkg::ADDR_W-1:epr_pkg::SLOT_LO] == 3'h1
    |=> o_instruction ==
      $past(fi.fixed[epr_pkg::INSTR_W +: epr_pkg::INSTR_W]))
    else $error("slot one not selected");

  slot_two_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && i_address[epr_pkg::ADDR_W-1:epr_pkg::SLOT_LO] == 3'h2
    |=> o_instruction == $past(fi.fixed[
      epr_pkg::LAST_SLOT*epr_pkg::INSTR_W +: epr_pkg::INSTR_W]))
    else $error("slot two not selected");

  clean_pass_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && i_address[epr_pkg::ADDR_W-1:epr_pkg::SLOT_LO] == 3'h0 &&
      epr_pkg::ecc_encode(fi.data) == fi.check
    |=> o_instruction == $past(fi.data[epr_pkg::INSTR_W-1:0]))
    else $error("clean slot zero altered");

  // Corrected data re-encodes to the stored check, or one check bit off
  fix_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && fi.sbe
    |-> $countones(epr_pkg::ecc_encode(fi.fixed) ^ fi.check) <= 1)
    else $error("single error not handled");

  single_seen_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && fi.sbe |=> o_single_error_flag)
    else $error("single error not flagged");

  double_seen_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable && fi.dbe |=> o_double_error_flag)
    else $error("double error not flagged");

  refetch_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_single_error_flag && !i_enable |=> o_single_error_flag)
    else $error("single flag dropped on held row");

  flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_enable
    |=> $stable(o_single_error_flag) && $stable(o_double_error_flag))
    else $error("flags moved without enable");

  any_slot_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable ##1 (i_enable && $stable(i_address[epr_pkg::ROW_W-1:0]))
    |=> $stable(o_double_error_flag))
    else $error("double flag depends on slot");

  range_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_enable &&
      i_address[epr_pkg::ADDR_W-1:epr_pkg::SLOT_LO] > epr_pkg::LAST_SLOT
    |=> o_single_error_flag == $past(fi.sbe))
    else $error("flag lost on forced slot");
endmodule

// >>> test/epr_cpu.sv
/*
  Fetching processor stand-in for the ECC program memory.
  Assumes the memory takes a fetch on a rising edge with enable high.
*/
`timescale 1ns/1ps
module epr_cpu (
  input  wire logic        i_clk,
  output logic      [11:0] o_address,
  output logic             o_enable
);
  initial begin
    o_address = 12'h000;
    o_enable  = 1'b0;
  end
  // Held through the taking edge; one fetch per two cycles, as if slowed
  task automatic fetch(input logic [11:0] a);
    @(posedge i_clk);
    o_address <= a;
    o_enable  <= 1'b1;
    @(posedge i_clk);
  endtask
  // Address keeps moving so a hold cannot come from a steady input
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_enable  <= 1'b0;
      o_address <= ~o_address;
    end
  endtask
endmodule

// >>> test/epr_rom_tb.sv
/*
  Self-checking bench for the ECC program memory.
  Assumes check bytes are taken from the init groups.
*/
`timescale 1ns/1ps
module epr_rom_tb;
  localparam logic [63:0] D = {10'h000, 18'h2ABCD, 18'h01234, 18'h0F0F0};
  function automatic logic [7:0] enc(input logic [63:0] d);
    logic [6:0] s;
    int         k;
    s = 7'h00;
    k = 0;
    for (int p = 3; k < 64; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) begin
          s = s ^ p[6:0];
        end
        k++;
      end
    end
    return {(^d) ^ (^s), s};
  endfunction
  localparam logic [7:0] C = enc(D);
  // Row 0x010 clean, 0x063 one bad bit, 0x086 two bad bits
  localparam logic [255:0] DG [128] = '{4: {192'h0, D},
    24: {D ^ 64'h100000, 192'h0}, 33: {64'h0, D ^ 64'h3, 128'h0},
    default: '0};
  localparam logic [31:0] CG [128] = '{4: {24'h0, C}, 24: {C, 24'h0},
    33: {8'h0, C, 16'h0}, default: '0};
  logic        i_clk;
  logic        i_nrst;
  logic [11:0] addr;
  logic        en;
  logic [17:0] instr;
  logic        sbe;
  logic        dbe;
  int          errors;
  int          comparisons;
  epr_cpu i_epr_cpu (.i_clk(i_clk), .o_address(addr), .o_enable(en));
  epr_rom #(
    .DATA_INIT_GROUP (DG),
    .CHECK_INIT_GROUP(CG),
    .CHECK_FROM_DATA (1'b0)
  ) i_epr_rom (
    .i_clk              (i_clk),
    .i_nrst             (i_nrst),
    .i_address          (addr),
    .i_enable           (en),
    .o_instruction      (instr),
    .o_single_error_flag(sbe),
    .o_double_error_flag(dbe)
  );
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] s,
                     input logic [17:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic look(input logic [17:0] ei, input logic es, input logic ed);
    #1;
    chk("instruction", instr, ei);
    chk("single flag", {17'h0, sbe}, {17'h0, es});
    chk("double flag", {17'h0, dbe}, {17'h0, ed});
  endtask
  task automatic t_clean();
    for (int s = 0; s < 3; s++) begin
      i_epr_cpu.fetch({s[2:0], 9'h010});
      look(D[s*18 +: 18], 1'b0, 1'b0);
    end
  endtask
  // Stored row stays bad, so every pass must flag again
  task automatic t_single();
    for (int r = 0; r < 6; r++) begin
      i_epr_cpu.fetch({r[2:0] % 3'h3, 9'h063});
      look(D[(r%3)*18 +: 18], 1'b1, 1'b0);
    end
  endtask
  task automatic t_double();
    for (int s = 0; s < 3; s++) begin
      i_epr_cpu.fetch({s[2:0], 9'h086});
      #1;
      chk("double flag", {17'h0, dbe}, 18'h00001);
      chk("single flag", {17'h0, sbe}, 18'h00000);
    end
  endtask
  task automatic t_range();
    i_epr_cpu.fetch(12'h610);
    look(18'h00000, 1'b0, 1'b0);
    i_epr_cpu.fetch(12'h663);
    look(18'h00000, 1'b1, 1'b0);
    i_epr_cpu.fetch(12'hE10);
    look(18'h00000, 1'b0, 1'b0);
  endtask
  task automatic t_hold();
    i_epr_cpu.fetch(12'h263);
    i_epr_cpu.idle(3);
    look(D[35:18], 1'b1, 1'b0);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    #20000;
    errors++;
    summarize();
  end
  initial begin
    errors      = 0;
    comparisons = 0;
    i_nrst      = 1'b0;
    repeat (5) @(posedge i_clk);
    look(18'h00000, 1'b0, 1'b0);
    i_nrst <= 1'b1;
    t_clean();
    t_single();
    t_double();
    t_range();
    t_hold();
    summarize();
  end
endmodule
